//--- verilog/dio_pkg.sv
// Constants, field layouts and carriers for the DDR I/O cell.
// Assumes one AHB-Lite master and a 250 MHz hclk.
// Behaviour
// R1: Pad input feeds two capture registers, one per half-period clock phase.
// R2: Both capture registers share one set/preset and one reset/clear.
// R3: Capture enable high loads alternate bits; low holds both capture registers.
// R4: Second phase is the inverse of the first, made inside the cell.
// R5: Two output data registers on opposite phases multiplex onto the pad.
// R6: Output data registers share one clock enable and the set/reset lines.
// R7: Pad shows data mux or high impedance, chosen by an enable mux.
// R8: Data and enable registers all share the set/preset and reset/clear.
// R9: Separate clock enables for data register pair and enable register pair.
// R10: First phase drives first data and enable registers; second drives others.
// R11: Both enable registers high gives high impedance; both low drives data.
// R12: First enable high only: hi-Z in first phase, second data in second.
// R13: Second enable high only: hi-Z in second phase, first data in first.
// R14: Mux select comes from the phase clock, never from software.
// R15: Every control and data signal into the registers is individually invertible.
// R16: Data and enable registers use one common pair of phase clocks.
// R17: Neighbouring cells must share the same input clock; placement concern.
// R18: Synchronous mode: reset forces low on either phase edge, beats set.
// R19: Asynchronous mode: preset forces high, clear forces low, without phase edges.
// R20: Registers load their data on their own phase edge with enable high.
// R21: After reset every register starts low.
// R22: Preset and clear together: clear wins and holds output low.
package dio_pkg;

  localparam int unsigned CLK_MHZ = 250;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_DATA = 8'h04;
  localparam logic [7:0] OFS_INV = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0C;
  localparam int unsigned OFS_W = 8;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'b0;
  localparam int unsigned PHASE_LEN_DEF = 1;

  typedef struct packed {
    logic async_mode;
    logic ce_cap;
    logic ce_data;
    logic ce_en;
    logic set;
    logic force_low;
    logic preset;
    logic async_force_low;
  } dio_ctl_t;

  typedef struct packed {
    logic d_first;
    logic d_second;
    logic t_first;
    logic t_second;
  } dio_dat_t;

  // Order of the inversion mask, low bit is the pad input
  typedef struct packed {
    dio_ctl_t ctl;
    dio_dat_t dat;
    logic pad_in;
  } dio_sig_t;

  localparam int unsigned CTL_W = $bits(dio_ctl_t);
  localparam int unsigned DAT_W = $bits(dio_dat_t);
  localparam int unsigned SIG_W = $bits(dio_sig_t);
  localparam logic [CTL_W-1:0] CTL_RST = '0;
  localparam logic [DAT_W-1:0] DAT_RST = '0;
  localparam logic [SIG_W-1:0] INV_RST = '0;

  typedef struct packed {
    logic phase_first;
    logic enable_reg_second;
    logic enable_reg_first;
    logic data_reg_second;
    logic data_reg_first;
    logic capture_out_b;
    logic capture_out_a;
  } dio_stat_t;

  localparam int unsigned STAT_W = $bits(dio_stat_t);

endpackage

//--- verilog/dio_cell.sv
// DDR I/O cell: input capture, DDR output and three-state DDR output.
// Assumes a single AHB-Lite master, hready driven from this slave's hreadyout,
// and a pad resolved by the bench from pad_out and pad_oe.
//
// Local design decisions: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
module dio_cell
#(
  parameter int unsigned PHASE_LEN = dio_pkg::PHASE_LEN_DEF
)
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic out_clock_first,
  output logic capture_out_a,
  output logic capture_out_b
);
  import dio_pkg::*;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  dio_ctl_t ctl_q, ctl_d;
  dio_dat_t dat_q, dat_d;
  logic [SIG_W-1:0] inv_q, inv_d;
  logic wr_pend_q, wr_pend_d;
  logic [OFS_W-1:0] wr_ofs_q, wr_ofs_d;
  logic [31:0] rdata_q, rdata_d;
  logic access;
  dio_stat_t stat;

  assign access = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_comb
  begin
    ctl_d = ctl_q;
    dat_d = dat_q;
    inv_d = inv_q;
    wr_pend_d = access && hwrite;
    wr_ofs_d = access ? haddr[OFS_W-1:0] : wr_ofs_q;
    rdata_d = rdata_q;
    if (wr_pend_q)
    begin
      case (wr_ofs_q)
        OFS_CTRL: ctl_d = dio_ctl_t'(hwdata[CTL_W-1:0]);
        OFS_DATA: dat_d = dio_dat_t'(hwdata[DAT_W-1:0]);
        OFS_INV: inv_d = hwdata[SIG_W-1:0];
        default: ;
      endcase
    end
    if (access && !hwrite)
    begin
      case (haddr[OFS_W-1:0])
        OFS_CTRL: rdata_d = {{(32-CTL_W){1'b0}}, ctl_q};
        OFS_DATA: rdata_d = {{(32-DAT_W){1'b0}}, dat_q};
        OFS_INV: rdata_d = {{(32-SIG_W){1'b0}}, inv_q};
        OFS_STAT: rdata_d = {{(32-STAT_W){1'b0}}, stat};
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctl_q <= CTL_RST;
      dat_q <= DAT_RST;
      inv_q <= INV_RST;
      wr_pend_q <= 1'b0;
      wr_ofs_q <= '0;
      rdata_q <= '0;
    end
    else
    begin
      ctl_q <= ctl_d;
      dat_q <= dat_d;
      inv_q <= inv_d;
      wr_pend_q <= wr_pend_d;
      wr_ofs_q <= wr_ofs_d;
      rdata_q <= rdata_d;
    end
  end

  // ----------------------------------------
  // Pad synchroniser and signal inversion
  // ----------------------------------------
  logic sync1_q, sync2_q;
  dio_sig_t eff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pad_in;
      sync2_q <= sync1_q;
    end
  end

  assign eff = dio_sig_t'({ctl_q, dat_q, sync2_q} ^ inv_q); // see R15

  // ----------------------------------------
  // Phase clock divider
  // ----------------------------------------
  localparam int unsigned CNT_W = (PHASE_LEN > 1) ? $clog2(PHASE_LEN) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(PHASE_LEN - 1);
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic second_q, second_d;
  logic tick, tick_first, tick_second;

  assign tick = (cnt_q == CNT_LAST);
  assign tick_first = tick && second_q;
  assign tick_second = tick && !second_q;

  always_comb
  begin
    cnt_d = tick ? '0 : cnt_q + CNT_W'(1);
    second_d = tick ? !second_q : second_q; // see R4
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cnt_q <= '0;
      second_q <= 1'b0;
    end
    else
    begin
      cnt_q <= cnt_d;
      second_q <= second_d;
    end
  end

  // ----------------------------------------
  // DDR registers
  // ----------------------------------------
  function automatic logic ddr_next(input logic q, input logic d, input logic edge_hit, input logic ce,
                                    input dio_ctl_t c);
    logic r;
    r = q;
    if (c.async_mode)
    begin
      if (c.async_force_low)
        r = 1'b0; // see R22
      else if (c.preset)
        r = 1'b1; // see R19
      else if (edge_hit && ce)
        r = d;
    end
    else if (edge_hit)
    begin
      if (c.force_low)
        r = 1'b0; // see R18
      else if (c.set)
        r = 1'b1;
      else if (ce)
        r = d; // see R20
    end
    return r;
  endfunction

  logic cap_a_q, cap_a_d, cap_b_q, cap_b_d;
  logic data_reg_first_q, data_reg_first_d, data_reg_second_q, data_reg_second_d;
  logic enable_reg_first_q, enable_reg_first_d, enable_reg_second_q, enable_reg_second_d;
  logic pad_out_q, pad_out_d, pad_oe_q, pad_oe_d, clk_first_q;
  logic hready_q;

  always_comb
  begin
    // Capture pair on shared controls; see R1 R2 R3
    cap_a_d = ddr_next(cap_a_q, eff.pad_in, tick_first, eff.ctl.ce_cap, eff.ctl);
    cap_b_d = ddr_next(cap_b_q, eff.pad_in, tick_second, eff.ctl.ce_cap, eff.ctl);
    // Data pair on one enable, enable pair on another; see R6 R8 R9 R10 R16
    data_reg_first_d = ddr_next(data_reg_first_q, eff.dat.d_first, tick_first, eff.ctl.ce_data, eff.ctl);
    data_reg_second_d = ddr_next(data_reg_second_q, eff.dat.d_second, tick_second, eff.ctl.ce_data, eff.ctl);
    enable_reg_first_d = ddr_next(enable_reg_first_q, eff.dat.t_first, tick_first, eff.ctl.ce_en, eff.ctl);
    enable_reg_second_d = ddr_next(enable_reg_second_q, eff.dat.t_second, tick_second, eff.ctl.ce_en, eff.ctl);
    // Muxes selected by phase only; see R5 R7 R11 R12 R13 R14
    pad_out_d = second_d ? data_reg_second_d : data_reg_first_d;
    pad_oe_d = !(second_d ? enable_reg_second_d : enable_reg_first_d);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // All start low; see R21
      cap_a_q <= 1'b0;
      cap_b_q <= 1'b0;
      data_reg_first_q <= 1'b0;
      data_reg_second_q <= 1'b0;
      enable_reg_first_q <= 1'b0;
      enable_reg_second_q <= 1'b0;
      pad_out_q <= 1'b0;
      pad_oe_q <= 1'b0;
      clk_first_q <= 1'b0;
      hready_q <= 1'b0;
    end
    else
    begin
      cap_a_q <= cap_a_d;
      cap_b_q <= cap_b_d;
      data_reg_first_q <= data_reg_first_d;
      data_reg_second_q <= data_reg_second_d;
      enable_reg_first_q <= enable_reg_first_d;
      enable_reg_second_q <= enable_reg_second_d;
      pad_out_q <= pad_out_d;
      pad_oe_q <= pad_oe_d;
      clk_first_q <= !second_d;
      hready_q <= 1'b1;
    end
  end

  assign stat = '{phase_first: clk_first_q, enable_reg_second: enable_reg_second_q, enable_reg_first: enable_reg_first_q,
                  data_reg_second: data_reg_second_q, data_reg_first: data_reg_first_q, capture_out_b: cap_b_q,
                  capture_out_a: cap_a_q};
  assign hrdata = rdata_q;
  assign hreadyout = hready_q;
  assign hresp = HRESP_OKAY;
  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign out_clock_first = clk_first_q;
  assign capture_out_a = cap_a_q;
  assign capture_out_b = cap_b_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  property p_data_mux;
    pad_out == (out_clock_first ? data_reg_first_q : data_reg_second_q);
  endproperty
  a_data_mux: assert property (p_data_mux) else $error("pad data not from phase register"); // see R5

  // Skips the release edge, where pad_oe still shows its reset value
  property p_en_mux;
    $past(hresetn) |-> (pad_oe == !(out_clock_first ? enable_reg_first_q : enable_reg_second_q));
  endproperty
  a_en_mux: assert property (p_en_mux) else $error("pad enable not from phase register"); // see R12

  property p_both_high;
    (enable_reg_first_q && enable_reg_second_q) |-> !pad_oe;
  endproperty
  a_both_high: assert property (p_both_high) else $error("pad driven with both enables high"); // see R11

  property p_capture;
    (tick_first && !eff.ctl.async_mode && !eff.ctl.force_low && !eff.ctl.set && eff.ctl.ce_cap)
      |=> (capture_out_a == $past(eff.pad_in));
  endproperty
  a_capture: assert property (p_capture) else $error("first capture missed pad bit"); // see R3

  property p_hold;
    (!tick && !eff.ctl.async_mode) |=> ($stable(capture_out_a) && $stable(capture_out_b) && $stable(data_reg_second_q));
  endproperty
  a_hold: assert property (p_hold) else $error("register changed without phase edge"); // see R1

  property p_sync_reset;
    (tick_first && !eff.ctl.async_mode && eff.ctl.force_low) |=> (!data_reg_first_q && !enable_reg_first_q && !capture_out_a);
  endproperty
  a_sync_reset: assert property (p_sync_reset) else $error("sync reset did not force low"); // see R18

  property p_sync_set;
    (tick_second && !eff.ctl.async_mode && !eff.ctl.force_low && eff.ctl.set) |=> (data_reg_second_q && enable_reg_second_q && capture_out_b);
  endproperty
  a_sync_set: assert property (p_sync_set) else $error("sync set did not force high"); // see R8

  property p_async_clear;
    (eff.ctl.async_mode && eff.ctl.async_force_low) |=> (!data_reg_first_q && !data_reg_second_q && !enable_reg_first_q && !enable_reg_second_q);
  endproperty
  a_async_clear: assert property (p_async_clear) else $error("async clear did not win"); // see R22

  property p_async_preset;
    (eff.ctl.async_mode && eff.ctl.preset && !eff.ctl.async_force_low) |=> (data_reg_first_q && data_reg_second_q);
  endproperty
  a_async_preset: assert property (p_async_preset) else $error("async preset did not force high"); // see R19

  property p_ce_data;
    (tick_first && !eff.ctl.async_mode && !eff.ctl.force_low && !eff.ctl.set && !eff.ctl.ce_data) |=> $stable(data_reg_first_q);
  endproperty
  a_ce_data: assert property (p_ce_data) else $error("data register loaded with enable low"); // see R6

  property p_phase;
    tick |=> (out_clock_first != $past(out_clock_first));
  endproperty
  a_phase: assert property (p_phase) else $error("phase did not alternate"); // see R14

  c_split_en: cover property (enable_reg_first_q && !enable_reg_second_q && pad_oe ##1 !pad_oe);
  c_capture_pair: cover property (tick_first && eff.ctl.ce_cap ##[1:8] tick_second && eff.ctl.ce_cap);
  c_async_clear: cover property (eff.ctl.async_mode && eff.ctl.async_force_low && eff.ctl.preset);
  c_write: cover property (wr_pend_q && wr_ofs_q == OFS_DATA);

endmodule

//--- bench/dio_pad_model.sv
// Pad and off-chip device model for the DDR I/O cell.
// Assumes the bench feeds pad_lvl to the cell's pad input.
`timescale 1ns/1ps
module dio_pad_model
#(
  parameter int unsigned HALF = 2
)
(
  input wire logic hclk,
  input wire logic pad_out,
  input wire logic pad_oe,
  input wire logic drv_en,
  input wire logic drv_tog,
  input wire logic drv_val,
  output logic pad_lvl
);
  logic last_q = 1'b0;
  logic tog_q = 1'b0;
  int cnt = 0;
  // Released line shows no stale value
  always_comb
  begin
    if (pad_oe)
      pad_lvl = pad_out;
    else if (drv_en)
      pad_lvl = drv_tog ? tog_q : drv_val;
    else
      pad_lvl = ~last_q;
  end
  // One shared clock for the cell pair
  always @(posedge hclk)
  begin
    last_q <= pad_lvl;
    cnt <= (cnt + 1) % HALF;
    if (cnt == HALF - 1)
      tog_q <= ~tog_q;
  end
endmodule

//--- bench/test_dio_cell.sv
// Self-checking bench for the DDR I/O cell over AHB-Lite.
// Assumes dio_pkg, dio_cell and dio_pad_model compiled first.
`timescale 1ns/1ps
module test_dio_cell;
  import dio_pkg::*;
  localparam int unsigned PL = 2;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic pad_in;
  logic pad_out;
  logic pad_oe;
  logic out_clock_first;
  logic capture_out_a;
  logic capture_out_b;
  logic drv_en = 1'b0;
  logic drv_tog = 1'b0;
  logic drv_val = 1'b0;
  logic [31:0] rd;
  int mismatches = 0;
  int checked = 0;

  always #2 hclk = ~hclk;

  dio_cell #(.PHASE_LEN(PL)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .out_clock_first(out_clock_first), .capture_out_a(capture_out_a), .capture_out_b(capture_out_b));
  dio_pad_model #(.HALF(PL)) u_pad (.hclk(hclk), .pad_out(pad_out), .pad_oe(pad_oe), .drv_en(drv_en),
    .drv_tog(drv_tog), .drv_val(drv_val), .pad_lvl(pad_in));

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic final_report();
    if (mismatches == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'(HRESP_OKAY), 32'(hresp));
  endtask

  // Write, then let both phase ticks pass
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (4 * PL) @(posedge hclk);
  endtask

  task automatic st(input string nm, input logic [31:0] mask, input logic [31:0] exp);
    bus(1'b0, OFS_STAT, 32'h0);
    chk(nm, exp, rd & mask);
  endtask

  task automatic pad_chk(input logic [3:0] dv);
    logic t;
    logic d;
    wr(OFS_DATA, {28'h0, dv});
    repeat (4 * PL)
    begin
      @(negedge hclk);
      t = out_clock_first ? dv[1] : dv[0];
      d = out_clock_first ? dv[3] : dv[2];
      chk("pad_oe", 32'(!t), 32'(pad_oe));
      if (!t)
        chk("pad_out", 32'(d), 32'(pad_out));
    end
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, 8'(i * 4), 32'h0);
      chk("reset_val", 32'h0, rd & 32'hFFFFFFBF);
    end
    bus(1'b1, 8'h10, 32'hFFFFFFFF);
    bus(1'b0, 8'h10, 32'h0);
    chk("unmapped", 32'h0, rd);
    wr(OFS_CTRL, 32'h70);
    bus(1'b0, OFS_CTRL, 32'h0);
    chk("ctrl", 32'h70, rd);
    for (int i = 0; i < 16; i++)
      pad_chk(4'(i));
    wr(OFS_CTRL, 32'h60);
    wr(OFS_DATA, 32'h0);
    st("ce_en_low", 32'h3C, 32'h30);
    wr(OFS_CTRL, 32'h50);
    wr(OFS_DATA, 32'hF);
    st("ce_data_low", 32'h3C, 32'h30);
    wr(OFS_CTRL, 32'h7C);
    st("sync_low", 32'h3F, 32'h0);
    chk("oe_low", 32'h2, 32'({pad_oe, pad_out}));
    wr(OFS_CTRL, 32'h78);
    st("sync_set", 32'h3F, 32'h3F);
    wr(OFS_CTRL, 32'h82);
    st("preset", 32'h3F, 32'h3F);
    wr(OFS_CTRL, 32'h83);
    st("both", 32'h3F, 32'h0);
    wr(OFS_CTRL, 32'h82);
    wr(OFS_CTRL, 32'h81);
    st("clear", 32'h3F, 32'h0);
    wr(OFS_CTRL, 32'h70);
    wr(OFS_DATA, 32'h0);
    wr(OFS_INV, 32'h1E);
    st("inv_data", 32'h3C, 32'h3C);
    wr(OFS_INV, 32'h9E);
    st("inv_ctl", 32'h3C, 32'h0);
    wr(OFS_INV, 32'h0);
    wr(OFS_DATA, 32'h3);
    drv_en <= 1'b1;
    drv_val <= 1'b1;
    wr(OFS_CTRL, 32'h70);
    chk("cap_one", 32'h3, 32'({capture_out_b, capture_out_a}));
    wr(OFS_CTRL, 32'h30);
    drv_val <= 1'b0;
    repeat (8 * PL) @(posedge hclk);
    chk("cap_hold", 32'h3, 32'({capture_out_b, capture_out_a}));
    wr(OFS_CTRL, 32'h70);
    chk("cap_zero", 32'h0, 32'({capture_out_b, capture_out_a}));
    wr(OFS_INV, 32'h1);
    chk("cap_inv", 32'h3, 32'({capture_out_b, capture_out_a}));
    wr(OFS_INV, 32'h0);
    drv_tog <= 1'b1;
    repeat (8 * PL) @(posedge hclk);
    repeat (4 * PL)
    begin
      @(negedge hclk);
      chk("cap_alt", 32'h1, 32'(capture_out_a ^ capture_out_b));
    end
    @(negedge hclk);
    rd = 32'(out_clock_first);
    repeat (PL) @(negedge hclk);
    chk("phase", 32'(!rd[0]), 32'(out_clock_first));
    drv_en <= 1'b0;
    final_report();
  end

  // Tests need well under a thousand cycles; allow far more
  initial
  begin
    #100000;
    mismatches++;
    final_report();
  end
endmodule
